/* hdl/ioctl_top.sv */
`timescale 1ns/100ps
// Contract
// - all pins analog high-z during reset
// - per-port pull-up or pull-down after release
// - reset configuration kept in nonvolatile store
// - store copied to config registers automatically
// - pins hold state in low power
// - pin interrupts active in low power
// - serial address wake only on special pins
// - every pin in boundary scan chain
// - per-pin rise, fall, both or none
module ioctl_top (
  input  wire logic                                                 clk,
  input  wire logic                                                 resetn,
  input  wire logic                                                 lp_mode,
  input  wire logic [ioctl_pkg::NPIN-1:0]                           pin_in,
  input  wire logic [ioctl_pkg::NPIN-1:0]                           drv_oe,
  input  wire logic [ioctl_pkg::NPIN-1:0]                           drv_out,
  input  wire logic [ioctl_pkg::NPIN-1:0][1:0]                      irq_mode,
  input  wire logic [ioctl_pkg::NPIN-1:0]                           irq_clr,
  input  wire logic [ioctl_pkg::NPIN-1:0]                           i2c_match,
  input  wire logic [ioctl_pkg::NPORT-1:0]                          cfg_we,
  input  wire logic [ioctl_pkg::NPORT-1:0][ioctl_pkg::CFG_W-1:0]    cfg_wdata,
  input  wire logic                                                 nv_wr_en,
  input  wire logic [ioctl_pkg::PIDX_W-1:0]                         nv_wr_addr,
  input  wire logic [ioctl_pkg::CFG_W-1:0]                          nv_wr_data,
  input  wire logic                                                 bs_capture,
  input  wire logic                                                 bs_shift,
  input  wire logic                                                 bs_tdi,
  output ioctl_pkg::ioctl_pad_s [ioctl_pkg::NPIN-1:0]               pad,
  output logic [ioctl_pkg::NPORT-1:0][ioctl_pkg::CFG_W-1:0]         port_cfg,
  output logic [ioctl_pkg::NPIN-1:0]                                irq_status,
  output logic                                                      wake,
  output logic                                                      cfg_ready,
  output logic                                                      bs_tdo
);

  ioctl_pkg::ioctl_state_s               s_q;
  ioctl_pkg::ioctl_state_s               s_d;
  logic [ioctl_pkg::CFG_W-1:0]           nv_rdata;
  logic                                  nv_rd_en;
  logic [ioctl_pkg::NPIN-1:0]            rise_m;
  logic [ioctl_pkg::NPIN-1:0]            fall_m;
  logic [ioctl_pkg::NPIN-1:0]            ev;

  // ****************************************
  // nonvolatile reset configuration store
  // ****************************************
  assign nv_rd_en = (s_q.st == ioctl_pkg::ST_READ);

  ioctl_nvm #(
    .DEPTH (ioctl_pkg::NPORT),
    .AW    (ioctl_pkg::PIDX_W),
    .W     (ioctl_pkg::CFG_W)
  ) u_nvm (
    .clk     (clk),
    .wr_en   (nv_wr_en),
    .wr_addr (nv_wr_addr),
    .wr_data (nv_wr_data),
    .rd_en   (nv_rd_en),
    .rd_addr (s_q.idx),
    .rd_data (nv_rdata)
  );

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    s_d = s_q;
    for (int i = 0; i < ioctl_pkg::NPIN; i++) begin
      rise_m[i] = irq_mode[i][ioctl_pkg::MODE_RISE];
      fall_m[i] = irq_mode[i][ioctl_pkg::MODE_FALL];
    end
    ev = (pin_in & ~s_q.prev & rise_m) | (~pin_in & s_q.prev & fall_m);
    unique case (s_q.st)
      ioctl_pkg::ST_READ: begin
        s_d.st = ioctl_pkg::ST_CAPT;
      end
      ioctl_pkg::ST_CAPT: begin
        s_d.cfg[s_q.idx] = nv_rdata;
        s_d.prev         = pin_in;
        if (s_q.idx == ioctl_pkg::PORT_LAST) begin
          s_d.st  = ioctl_pkg::ST_RUN;
          s_d.rdy = 1'h1;
        end else begin
          s_d.idx = s_q.idx + ioctl_pkg::PORT_STEP;
          s_d.st  = ioctl_pkg::ST_READ;
        end
      end
      ioctl_pkg::ST_RUN: begin
        for (int p = 0; p < ioctl_pkg::NPORT; p++) begin
          if (cfg_we[p]) begin
            s_d.cfg[p] = cfg_wdata[p];
          end
        end
        // edge detect keeps running in low power
        s_d.prev = pin_in;
        s_d.irq  = (s_q.irq & ~irq_clr) | ev;
        s_d.wake = lp_mode & ((|ev) | (|(i2c_match & ioctl_pkg::I2C_WAKE_PINS)));
        if (!lp_mode) begin
          for (int i = 0; i < ioctl_pkg::NPIN; i++) begin
            s_d.pad[i].oe  = drv_oe[i];
            s_d.pad[i].out = drv_out[i];
            s_d.pad[i].pu  = (s_q.cfg[i / ioctl_pkg::PPORT] == ioctl_pkg::CFG_PUP);
            s_d.pad[i].pd  = (s_q.cfg[i / ioctl_pkg::PPORT] == ioctl_pkg::CFG_PDN);
            s_d.pad[i].ana = (s_q.cfg[i / ioctl_pkg::PPORT] == ioctl_pkg::CFG_HIZ)
                             && !drv_oe[i];
          end
        end
      end
      default: begin
        s_d.st = ioctl_pkg::ST_READ;
      end
    endcase
    // boundary scan cells on every pin
    if (bs_capture) begin
      s_d.bscan = pin_in;
    end else if (bs_shift) begin
      s_d.bscan = {bs_tdi, s_q.bscan[ioctl_pkg::NPIN-1:1]};
    end
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_q.st    <= ioctl_pkg::ST_READ;
      s_q.idx   <= ioctl_pkg::PORT_FIRST;
      s_q.cfg   <= {ioctl_pkg::NPORT{ioctl_pkg::CFG_HIZ}};
      s_q.pad   <= {ioctl_pkg::NPIN{ioctl_pkg::PAD_HIZ}};
      s_q.prev  <= '0;
      s_q.irq   <= '0;
      s_q.wake  <= 1'h0;
      s_q.rdy   <= 1'h0;
      s_q.bscan <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign pad        = s_q.pad;
  assign port_cfg   = s_q.cfg;
  assign irq_status = s_q.irq;
  assign wake       = s_q.wake;
  assign cfg_ready  = s_q.rdy;
  assign bs_tdo     = s_q.bscan[0];

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  a_hiz_until_run: assert property (
    !cfg_ready |-> pad == {ioctl_pkg::NPIN{ioctl_pkg::PAD_HIZ}})
    else $error("pins left high-z before configuration");

  a_copy_to_cfg: assert property (
    s_q.st == ioctl_pkg::ST_CAPT |=> port_cfg[$past(s_q.idx)] == $past(nv_rdata))
    else $error("stored reset data not copied");

  a_load_then_run: assert property (
    (s_q.st == ioctl_pkg::ST_CAPT && s_q.idx == ioctl_pkg::PORT_LAST)
      |=> cfg_ready ##1
        ($past(lp_mode) || pad[0].pu == ($past(port_cfg[0]) == ioctl_pkg::CFG_PUP)))
    else $error("release did not follow load");

  a_port_reprog: assert property (
    cfg_ready && cfg_we[1] |=> port_cfg[1] == $past(cfg_wdata[1]))
    else $error("port reconfiguration lost");

  a_lp_hold: assert property (
    cfg_ready && lp_mode |=> pad == $past(pad))
    else $error("pin changed in low power");

  a_irq_rise: assert property (
    cfg_ready && irq_mode[0][ioctl_pkg::MODE_RISE] && pin_in[0] && !s_q.prev[0]
      |=> irq_status[0] ##1 (irq_status[0] || $past(irq_clr[0])))
    else $error("rising edge not flagged");

  a_irq_set_wins: assert property (
    cfg_ready && ev[0] && irq_clr[0] |=> irq_status[0])
    else $error("event lost against clear");

  a_lp_irq_wake: assert property (
    cfg_ready && lp_mode && (|ev) |=> wake)
    else $error("pin event failed to wake");

  a_i2c_wake_pins: assert property (
    cfg_ready && lp_mode && ev == '0 && (i2c_match & ioctl_pkg::I2C_WAKE_PINS) == '0
      |=> !wake)
    else $error("wake from non-special serial pin");

  a_bscan_shift: assert property (
    bs_shift && !bs_capture ##1 bs_shift && !bs_capture
      |=> bs_tdo == $past(s_q.bscan[2], 2))
    else $error("scan chain shift broken");

  c_load_done: cover property (!cfg_ready ##1 cfg_ready);
  c_lp_wake:   cover property (cfg_ready && lp_mode ##1 wake);
  c_irq_both:  cover property (irq_mode[0] == 2'h3 && ev[0] ##1 irq_status[0]);

endmodule

/* hdl/ioctl_pkg.sv */
package ioctl_pkg;

  // ****************************************
  // sizes
  // ****************************************
  localparam int NPORT  = 4;
  localparam int PPORT  = 8;
  localparam int NPIN   = NPORT * PPORT;
  localparam int PIDX_W = 2;
  localparam int CFG_W  = 2;

  localparam logic [PIDX_W-1:0] PORT_FIRST = 2'h0;
  localparam logic [PIDX_W-1:0] PORT_LAST  = 2'h3;
  localparam logic [PIDX_W-1:0] PORT_STEP  = 2'h1;

  // ****************************************
  // per-port reset configuration codes
  // ****************************************
  localparam logic [CFG_W-1:0] CFG_HIZ = 2'h0;
  localparam logic [CFG_W-1:0] CFG_PDN = 2'h1;
  localparam logic [CFG_W-1:0] CFG_PUP = 2'h2;

  // ****************************************
  // pin interrupt mode bits
  // ****************************************
  localparam int MODE_RISE = 0;
  localparam int MODE_FALL = 1;

  // pins able to wake on serial address match
  localparam logic [NPIN-1:0] I2C_WAKE_PINS = 32'h0000_00c0;

  // ****************************************
  // types
  // ****************************************
  typedef struct packed {
    logic oe;
    logic out;
    logic pu;
    logic pd;
    logic ana;
  } ioctl_pad_s;

  localparam ioctl_pad_s PAD_HIZ = 5'h01;

  typedef enum logic [1:0] {ST_READ, ST_CAPT, ST_RUN} ioctl_st_e;

  typedef struct packed {
    ioctl_st_e                      st;
    logic [PIDX_W-1:0]              idx;
    logic [NPORT-1:0][CFG_W-1:0]    cfg;
    ioctl_pad_s [NPIN-1:0]          pad;
    logic [NPIN-1:0]                prev;
    logic [NPIN-1:0]                irq;
    logic                           wake;
    logic                           rdy;
    logic [NPIN-1:0]                bscan;
  } ioctl_state_s;

endpackage

/* hdl/ioctl_nvm.sv */
`timescale 1ns/100ps
module ioctl_nvm #(
  parameter int DEPTH = 4,
  parameter int AW    = 2,
  parameter int W     = 2
) (
  input  wire logic          clk,
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [W-1:0]  wr_data,
  input  wire logic          rd_en,
  input  wire logic [AW-1:0] rd_addr,
  output logic      [W-1:0]  rd_data
);

  // ****************************************
  // storage, untouched by reset
  // ****************************************
  logic [W-1:0] mem [DEPTH];

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    if (rd_en) begin
      rd_data <= mem[rd_addr];
    end
  end

  // ****************************************
  // checks
  // ****************************************
  a_nvm_retain: assert property (@(posedge clk)
    (wr_en ##1 (rd_en && !wr_en && rd_addr == $past(wr_addr)))
      |=> rd_data == $past(wr_data, 2))
    else $error("stored reset data not returned");

endmodule

/* sim/ioctl_board.sv */
`timescale 1ns/100ps
module ioctl_board (
  input  wire logic                                   clk,
  input  wire ioctl_pkg::ioctl_pad_s [ioctl_pkg::NPIN-1:0] pad,
  input  wire logic [ioctl_pkg::NPIN-1:0]             ext_en,
  input  wire logic [ioctl_pkg::NPIN-1:0]             ext_val,
  output logic      [ioctl_pkg::NPIN-1:0]             pin_in
);
  // ********
  // board level on each pin
  // ********
  logic [ioctl_pkg::NPIN-1:0] flt_q = '0;
  always_ff @(posedge clk) begin
    flt_q <= ~flt_q;
  end
  always_comb begin
    for (int i = 0; i < ioctl_pkg::NPIN; i++) begin
      if (pad[i].oe) begin
        pin_in[i] = pad[i].out;
      end else if (ext_en[i]) begin
        pin_in[i] = ext_val[i];
      end else if (pad[i].pu || pad[i].pd) begin
        pin_in[i] = pad[i].pu;
      end else begin
        pin_in[i] = flt_q[i];
      end
    end
  end
endmodule

/* sim/tb.sv */
`timescale 1ns/100ps
module tb;
  // ********
  // signals
  // ********
  logic clk = 0, resetn = 0, lp_mode = 0, wake, cfg_ready, bs_tdo;
  logic nv_wr_en = 0, bs_capture = 0, bs_shift = 0, bs_tdi = 0;
  logic [31:0] drv_oe = 0, drv_out = 0, irq_clr = 0, i2c_match = 0;
  logic [31:0] ext_en = '1, ext_val = 0, irq_status, pin_in;
  logic [31:0][1:0] irq_mode = 0;
  logic [3:0] cfg_we = 0;
  logic [1:0] nv_wr_addr = 0, nv_wr_data = 0;
  logic [3:0][1:0] cfg_wdata = 0, port_cfg, ecfg = 0;
  ioctl_pkg::ioctl_pad_s [31:0] pad;
  int n_mismatch = 0, total_checks = 0, cycles = 0;
  always #2.5 clk = ~clk;
  ioctl_top ioctl_top_i (.clk, .resetn, .lp_mode, .pin_in, .drv_oe, .drv_out,
    .irq_mode, .irq_clr, .i2c_match, .cfg_we, .cfg_wdata, .nv_wr_en, .nv_wr_addr,
    .nv_wr_data, .bs_capture, .bs_shift, .bs_tdi, .pad, .port_cfg, .irq_status,
    .wake, .cfg_ready, .bs_tdo);
  ioctl_board ioctl_board_i (.clk, .pad, .ext_en, .ext_val, .pin_in);
  // ********
  // tasks
  // ********
  task chk(input string nm, input logic [159:0] e, input logic [159:0] g);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask
  task tick(input int n);
    repeat (n) begin
      @(posedge clk);
      #1;
    end
  endtask
  function automatic logic [159:0] epads();
    ioctl_pkg::ioctl_pad_s [31:0] p;
    for (int i = 0; i < 32; i++) begin
      p[i] = ioctl_pkg::ioctl_pad_s'({drv_oe[i], drv_out[i], ecfg[i/8] == ioctl_pkg::CFG_PUP,
        ecfg[i/8] == ioctl_pkg::CFG_PDN, ecfg[i/8] == ioctl_pkg::CFG_HIZ && !drv_oe[i]});
    end
    return p;
  endfunction
  task wake_pulse(input logic [31:0] m, output logic w);
    i2c_match = m;
    w = 0;
    repeat (3) begin
      tick(1);
      i2c_match = 0;
      if (wake === 1'b1) w = 1;
    end
  endtask
  task t_reset_load(input logic [3:0][1:0] c);
    int n;
    resetn = 0;
    for (int p = 3; p >= 0; p--) begin
      nv_wr_en = 1;
      nv_wr_addr = p[1:0];
      nv_wr_data = c[p];
      tick(1);
    end
    nv_wr_en = 0;
    tick(16);
    chk("pads in reset", {32{ioctl_pkg::PAD_HIZ}}, pad);
    chk("ready in reset", 0, {cfg_ready, port_cfg, irq_status});
    resetn = 1;
    cfg_we = 4'hf;
    cfg_wdata = '1;
    n = 0;
    while (cfg_ready !== 1'b1 && n < 20) begin
      tick(1);
      n++;
      cfg_we = 0;
      chk("pads while loading", {32{ioctl_pkg::PAD_HIZ}}, pad);
    end
    chk("load cycles", 8, n);
    chk("loaded config", c, port_cfg);
    ecfg = c;
    tick(1);
    chk("pads after load", epads(), pad);
  endtask
  task t_reprog();
    cfg_wdata[1] = 2'h3;
    cfg_wdata[2] = ioctl_pkg::CFG_PDN;
    cfg_we = 4'h6;
    tick(1);
    cfg_we = 0;
    ecfg[1] = 2'h3;
    ecfg[2] = ioctl_pkg::CFG_PDN;
    chk("port config", ecfg, port_cfg);
    tick(1);
    chk("pads after write", epads(), pad);
  endtask
  task t_irq();
    for (int m = 0; m < 4; m++) begin
      irq_mode[0] = m[1:0];
      ext_val[0] = 1;
      tick(2);
      chk("rise event", m[0], irq_status[0]);
      ext_val[0] = 0;
      tick(2);
      chk("fall event", m[0] | m[1], irq_status[0]);
      irq_clr[0] = 1;
      tick(1);
      irq_clr[0] = 0;
      chk("cleared", 0, irq_status[0]);
    end
    irq_mode[0] = 2'h1;
    ext_val[0] = 1;
    irq_clr[0] = 1;
    tick(1);
    chk("set over clear", 1, irq_status[0]);
    ext_val[0] = 0;
    tick(1);
    irq_clr[0] = 0;
    chk("cleared again", 0, irq_status[0]);
  endtask
  task t_lowpower();
    logic [159:0] held;
    logic w;
    held = epads();
    lp_mode = 1;
    drv_oe = 32'h0000_ff00;
    drv_out = 32'h0000_5a00;
    irq_mode[0] = 2'h1;
    tick(3);
    chk("pads in low power", held, pad);
    chk("idle wake", 0, wake);
    ext_val[0] = 1;
    wake_pulse(0, w);
    chk("pin wake", 1, w);
    chk("low power status", 1, irq_status[0]);
    for (int p = 0; p < 8; p++) begin
      wake_pulse(32'h1 << p, w);
      chk("serial wake", ioctl_pkg::I2C_WAKE_PINS[p], w);
    end
    lp_mode = 0;
    wake_pulse(32'h0000_0040, w);
    chk("awake serial", 0, w);
    chk("pads after wake", epads(), pad);
  endtask
  task t_scan();
    logic [31:0] pat;
    ext_val = 32'h3c96_a5e1;
    ext_en = 32'h0000_ffff;
    drv_oe = 0;
    pat = {8'hff, 8'h00, ext_val[15:0]};
    tick(2);
    bs_capture = 1;
    tick(1);
    bs_capture = 0;
    bs_shift = 1;
    for (int i = 0; i < 32; i++) begin
      chk("scan out", pat[i], bs_tdo);
      tick(1);
    end
    bs_shift = 0;
    ext_en = '1;
  endtask
  task test_done();
    $display("checks %0d, mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      test_done();
    end
  end
  initial begin
    t_reset_load(8'h89);
    t_reprog();
    t_irq();
    t_lowpower();
    t_scan();
    drv_oe = 32'hf000_000f;
    drv_out = 32'h5000_0005;
    t_reset_load(8'h27);
    test_done();
  end
endmodule
